// ---- urxw_cfg.svh ----
`ifndef URXW_CFG_SVH
`define URXW_CFG_SVH

// register addresses on the plain register port
`define URXW_ADDR_RCSC 3'h0
`define URXW_ADDR_HOLD 3'h1
`define URXW_ADDR_TXSC 3'h2
`define URXW_ADDR_BAUD 3'h3
`define URXW_ADDR_DIVH 3'h4
`define URXW_ADDR_DIVL 3'h5
`define URXW_ADDR_IRQC 3'h6

// receive_status_control fields
`define URXW_RCSC_PORT_EN 7
`define URXW_RCSC_NINE_EN 6
`define URXW_RCSC_SREN 5
`define URXW_RCSC_CONTINUOUS_RECEIVE_ENABLE 4
`define URXW_RCSC_ADDRESS_DETECT_ENABLE 3
`define URXW_RCSC_FRAMING_ERROR 2
`define URXW_RCSC_OVERRUN_ERROR 1
`define URXW_RCSC_NINTH 0

// transmit_status_control fields used by the receiver
`define URXW_TXSC_SYNC 4
`define URXW_TXSC_HISPD 2

// baud_control fields
`define URXW_BAUD_RCIDL 6
`define URXW_BAUD_RXINV 5
`define URXW_BAUD_TXINV 4
`define URXW_BAUD_WIDE 3
`define URXW_BAUD_WUE 1

// irq control fields
`define URXW_IRQC_IE 0
`define URXW_IRQC_FLAG 1

// reset values
`define URXW_RST_BYTE 8'h00
`define URXW_RST_DIV 16'h0000

// bit timing, in oversample ticks, plus slow prescale limit and data bit count
`define URXW_OVERSAMPLE 5'h10
`define URXW_PH_S1 4'h7
`define URXW_PH_S2 4'h8
`define URXW_PH_DECIDE 4'h9
`define URXW_PRESCALE_SLOW 2'h3
`define URXW_DATA_BITS 4'h8

`endif

// ---- urxw_pkg.sv ----
package urxw_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_STOP  = 3'b011,
    ST_WAKE  = 3'b100
  } urxw_state_type;

endpackage : urxw_pkg

// ---- urxw_sync.sv ----
`timescale 1ns/100ps
// two-flop synchroniser for the serial input pin
module urxw_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin side
  input wire logic din,
  // clock side
  output logic dout
);

  logic meta_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : urxw_sync

// ---- urxw_baud.sv ----
`timescale 1ns/100ps
`include "urxw_cfg.svh"
// oversample tick generator; tick is one cycle long unless reload and prescale limit are both zero
module urxw_baud
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic wide,
  input wire logic hispd,
  input wire logic [15:0] divisor,
  // output
  output logic tick
);

  logic [15:0] cnt_q;
  logic [1:0] pre_q;
  logic [15:0] reload;
  logic [1:0] pre_lim;
  logic cnt_end;

  // narrow divisor uses only the low byte
  assign reload = wide ? divisor : {8'h00, divisor[7:0]};
  // slowest scheme runs the counter a further four times slower
  assign pre_lim = (!wide && !hispd) ? `URXW_PRESCALE_SLOW : 2'h0;
  assign cnt_end = (cnt_q == 16'h0000);
  assign tick = run && cnt_end && (pre_q == pre_lim);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end
    else if (!run)
    begin
      cnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end
    else if (cnt_end)
    begin
      cnt_q <= reload;
      pre_q <= (pre_q == pre_lim) ? 2'h0 : pre_q + 2'h1;
    end
    else
    begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

endmodule : urxw_baud

// ---- urxw_top.sv ----
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "urxw_cfg.svh"
// Functional notes
// - bits are sampled by a x16 oversampler feeding a bit-rate shifter
// - receive polarity invert bit inverts the serial input before sampling
// - bit timing comes from divisor bytes, high-speed and wide select
// - asynchronous operation needs clocked-mode clear and port enable set
// - characters are accepted only while continuous receive is enabled
// - nine-bit enable receives a ninth bit, readable in receive status
// - receive flag set on a complete character; irq only if enabled
// - receive status shows ninth bit and error indications
// - reading the holding register returns the low eight data bits
// - clearing continuous receive enable clears the overrun error; framing error is kept
// - address filtering needs nine-bit receive as well as its enable
// - address detect withholds ordinary characters; cleared, all pass
// - in sleep the baud generator stops and no character is received
// - wake-on-edge enable suspends reception and watches for wake
// - a falling edge on the receive line is the wake event
// - auto-wake-up works only in asynchronous mode
// - wake sets receive flag; synchronous when running, async in sleep
// - reading the holding register clears the receive flag
// - first rising edge after wake clears wake enable, normal resumes
// - the first rising edge after the wake fall ends the wake condition, even mid character
// - characters travel least significant bit first
// - framing is one start, eight or nine data, one stop bit
module urxw_top
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // serial line
  input wire logic SERIAL_IN_PIN,
  // power state
  input wire logic SLEEP,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // status
  output logic RECEIVE_FLAG,
  output logic RX_IRQ
);

  // control registers
  logic port_enable_q;
  logic nine_bit_receive_enable_q;
  logic sren_q;
  logic continuous_receive_enable_q;
  logic address_detect_enable_q;
  logic sync_mode_q;
  logic high_speed_select_q;
  logic rx_polarity_invert_q;
  logic tx_polarity_invert_q;
  logic wide_divisor_select_q;
  logic wake_on_edge_enable_q;
  logic receive_irq_enable_q;
  logic [7:0] baud_divisor_high_q;
  logic [7:0] baud_divisor_low_q;

  // status and data
  logic [7:0] receive_holding_q;
  logic ninth_received_bit_q;
  logic framing_error_q;
  logic overrun_error_q;
  logic receive_flag_q;
  logic wake_armed_q;
  logic [7:0] rdata_q;

  // receiver
  urxw_pkg::urxw_state_type state_q;
  logic [3:0] phase_q;
  logic [3:0] bit_cnt_q;
  logic [8:0] shift_q;
  logic samp1_q;
  logic samp2_q;
  logic line_prev_q;

  logic pin_sync;
  logic serial_in_line;
  logic async_en;
  logic run;
  logic tick;
  logic decide;
  logic bit_val;
  logic char_done;
  logic addr_filter;
  logic keep_char;
  logic accept;
  logic wake_active;
  logic wake_fall;
  logic wake_rise;
  logic wr_rcsc;
  logic wr_baud;
  logic rd_hold;
  logic sleep_wake;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  urxw_sync u_sync
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .din(SERIAL_IN_PIN),
    .dout(pin_sync)
  );

  assign serial_in_line = pin_sync ^ rx_polarity_invert_q;
  assign async_en = port_enable_q && !sync_mode_q;
  assign wake_active = async_en && wake_on_edge_enable_q;
  // the baud generator stands still in sleep and while waiting for wake
  assign run = async_en && continuous_receive_enable_q && !SLEEP
    && !wake_on_edge_enable_q && !overrun_error_q;

  urxw_baud u_baud
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .run(run),
    .wide(wide_divisor_select_q),
    .hispd(high_speed_select_q),
    .divisor({baud_divisor_high_q, baud_divisor_low_q}),
    .tick(tick)
  );

  assign wr_rcsc = WR && (ADDR == `URXW_ADDR_RCSC);
  assign wr_baud = WR && (ADDR == `URXW_ADDR_BAUD);
  assign rd_hold = RD && (ADDR == `URXW_ADDR_HOLD);

  assign decide = tick && (phase_q == `URXW_PH_DECIDE);
  assign bit_val = maj3(samp1_q, samp2_q, serial_in_line);
  assign char_done = decide && (state_q == urxw_pkg::ST_STOP);
  assign addr_filter = address_detect_enable_q
    && nine_bit_receive_enable_q;
  // ninth bit sits in the top of the shifter after nine data bits
  assign keep_char = !addr_filter || shift_q[8];
  assign accept = char_done && keep_char && !receive_flag_q;

  assign wake_fall = wake_active && line_prev_q && !serial_in_line;
  assign wake_rise = wake_active && wake_armed_q
    && !line_prev_q && serial_in_line;

  // configuration writes
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      port_enable_q <= 1'b0;
      nine_bit_receive_enable_q <= 1'b0;
      sren_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
      address_detect_enable_q <= 1'b0;
      sync_mode_q <= 1'b0;
      high_speed_select_q <= 1'b0;
      rx_polarity_invert_q <= 1'b0;
      tx_polarity_invert_q <= 1'b0;
      wide_divisor_select_q <= 1'b0;
      receive_irq_enable_q <= 1'b0;
      baud_divisor_high_q <= `URXW_RST_BYTE;
      baud_divisor_low_q <= `URXW_RST_BYTE;
    end
    else if (WR)
    begin
      unique case (ADDR)
        `URXW_ADDR_RCSC:
        begin
          port_enable_q <= WDATA[`URXW_RCSC_PORT_EN];
          nine_bit_receive_enable_q <= WDATA[`URXW_RCSC_NINE_EN];
          sren_q <= WDATA[`URXW_RCSC_SREN];
          continuous_receive_enable_q <= WDATA[`URXW_RCSC_CONTINUOUS_RECEIVE_ENABLE];
          address_detect_enable_q <= WDATA[`URXW_RCSC_ADDRESS_DETECT_ENABLE];
        end
        `URXW_ADDR_TXSC:
        begin
          sync_mode_q <= WDATA[`URXW_TXSC_SYNC];
          high_speed_select_q <= WDATA[`URXW_TXSC_HISPD];
        end
        `URXW_ADDR_BAUD:
        begin
          rx_polarity_invert_q <= WDATA[`URXW_BAUD_RXINV];
          tx_polarity_invert_q <= WDATA[`URXW_BAUD_TXINV];
          wide_divisor_select_q <= WDATA[`URXW_BAUD_WIDE];
        end
        `URXW_ADDR_DIVH: baud_divisor_high_q <= WDATA;
        `URXW_ADDR_DIVL: baud_divisor_low_q <= WDATA;
        `URXW_ADDR_IRQC: receive_irq_enable_q <= WDATA[`URXW_IRQC_IE];
        default:
        begin
        end
      endcase
    end
  end

  // wake-on-edge enable: software sets it, hardware ends it on rising edge
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      wake_on_edge_enable_q <= 1'b0;
    else if (wr_baud)
      wake_on_edge_enable_q <= WDATA[`URXW_BAUD_WUE];
    else if (wake_rise)
      wake_on_edge_enable_q <= 1'b0;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      wake_armed_q <= 1'b0;
    else if (!wake_active || wake_rise)
      wake_armed_q <= 1'b0;
    else if (wake_fall)
      wake_armed_q <= 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      line_prev_q <= 1'b1;
    else
      line_prev_q <= serial_in_line;
  end

  // receive state machine, advanced only on oversample ticks
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= urxw_pkg::ST_IDLE;
      phase_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 9'h000;
      samp1_q <= 1'b1;
      samp2_q <= 1'b1;
    end
    else if (wake_active)
    begin
      state_q <= urxw_pkg::ST_WAKE;
      phase_q <= 4'h0;
    end
    else if (!run)
    begin
      // an aborted frame is dropped rather than completed late
      state_q <= urxw_pkg::ST_IDLE;
      phase_q <= 4'h0;
    end
    else if (tick)
    begin
      phase_q <= phase_q + 4'h1;
      if (phase_q == `URXW_PH_S1)
        samp1_q <= serial_in_line;
      if (phase_q == `URXW_PH_S2)
        samp2_q <= serial_in_line;
      unique case (state_q)
        urxw_pkg::ST_IDLE, urxw_pkg::ST_WAKE:
        begin
          phase_q <= 4'h1;
          if (!serial_in_line)
            state_q <= urxw_pkg::ST_START;
          else
            state_q <= urxw_pkg::ST_IDLE;
        end
        urxw_pkg::ST_START:
        begin
          if (decide)
          begin
            bit_cnt_q <= 4'h0;
            // a start bit that has gone high again is a glitch
            state_q <= bit_val ? urxw_pkg::ST_IDLE : urxw_pkg::ST_DATA;
          end
        end
        urxw_pkg::ST_DATA:
        begin
          if (decide)
          begin
            shift_q <= {bit_val, shift_q[8:1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == (nine_bit_receive_enable_q ?
                `URXW_DATA_BITS : `URXW_DATA_BITS - 4'h1))
              state_q <= urxw_pkg::ST_STOP;
          end
        end
        urxw_pkg::ST_STOP:
        begin
          if (decide)
          begin
            // eight-bit frames sit one place high; realign
            if (!nine_bit_receive_enable_q)
              shift_q <= {1'b0, shift_q[8:1]};
            state_q <= urxw_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // holding register and its status
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      receive_holding_q <= `URXW_RST_BYTE;
      ninth_received_bit_q <= 1'b0;
      framing_error_q <= 1'b0;
    end
    else if (accept)
    begin
      if (nine_bit_receive_enable_q)
      begin
        receive_holding_q <= shift_q[7:0];
        ninth_received_bit_q <= shift_q[8];
      end
      else
      begin
        receive_holding_q <= shift_q[8:1];
        ninth_received_bit_q <= 1'b0;
      end
      framing_error_q <= !bit_val;
    end
  end

  // a character finishing while the last one is unread is an overrun
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      overrun_error_q <= 1'b0;
    else if (char_done && keep_char && receive_flag_q)
      overrun_error_q <= 1'b1;
    else if (!continuous_receive_enable_q)
      overrun_error_q <= 1'b0;
  end

  // receive flag: a wake fall in the clearing cycle wins over the read; a character then counts as overrun
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      receive_flag_q <= 1'b0;
    else if (accept || wake_fall)
      receive_flag_q <= 1'b1;
    else if (rd_hold)
      receive_flag_q <= 1'b0;
  end

  // while asleep the clock cannot be relied on, so the wake flag is also
  // raised straight from the pin
  assign sleep_wake = SLEEP && wake_active
    && !(SERIAL_IN_PIN ^ rx_polarity_invert_q);
  assign RECEIVE_FLAG = receive_flag_q || sleep_wake;
  assign RX_IRQ = RECEIVE_FLAG && receive_irq_enable_q;

  // read port, data one cycle after the strobe
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_q <= 8'h00;
    else if (RD)
    begin
      unique case (ADDR)
        `URXW_ADDR_RCSC:
          rdata_q <= {port_enable_q, nine_bit_receive_enable_q, sren_q,
            continuous_receive_enable_q, address_detect_enable_q,
            framing_error_q, overrun_error_q, ninth_received_bit_q};
        `URXW_ADDR_HOLD: rdata_q <= receive_holding_q;
        `URXW_ADDR_TXSC:
          rdata_q <= {3'h0, sync_mode_q, 1'b0, high_speed_select_q, 2'h0};
        `URXW_ADDR_BAUD:
          rdata_q <= {1'b0, (state_q == urxw_pkg::ST_IDLE),
            rx_polarity_invert_q, tx_polarity_invert_q,
            wide_divisor_select_q, 1'b0, wake_on_edge_enable_q, 1'b0};
        `URXW_ADDR_DIVH: rdata_q <= baud_divisor_high_q;
        `URXW_ADDR_DIVL: rdata_q <= baud_divisor_low_q;
        `URXW_ADDR_IRQC:
          rdata_q <= {6'h00, receive_flag_q, receive_irq_enable_q};
        default: rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  assign RDATA = rdata_q;

endmodule : urxw_top

// ---- urxw_checker.sv ----
`timescale 1ns/100ps
`include "urxw_cfg.svh"
// sees only the top ports; control bits are shadowed from register writes
module urxw_checker
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // stimulus
  input wire logic SERIAL_IN_PIN,
  input wire logic SLEEP,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  // responses
  input wire logic [7:0] RDATA,
  input wire logic RECEIVE_FLAG,
  input wire logic RX_IRQ
);
  logic ie_q;
  logic on_q;
  logic sync_q;
  logic wue_q;
  logic pin_q;
  logic hold_rd;
  assign hold_rd = RD && ADDR == `URXW_ADDR_HOLD;
  // wake shadow drops on the raw rise, earlier than the design: loosens the wake checks, tightens a_hold_clears and a_flag_cause
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ie_q <= 1'b0;
      on_q <= 1'b0;
      sync_q <= 1'b0;
      wue_q <= 1'b0;
      pin_q <= 1'b1;
    end
    else
    begin
      pin_q <= SERIAL_IN_PIN;
      if (WR && ADDR == `URXW_ADDR_IRQC)
        ie_q <= WDATA[0];
      if (WR && ADDR == `URXW_ADDR_RCSC)
        on_q <= WDATA[7] && WDATA[4];
      if (WR && ADDR == `URXW_ADDR_TXSC)
        sync_q <= WDATA[4];
      if (WR && ADDR == `URXW_ADDR_BAUD)
        wue_q <= WDATA[1];
      else if (!pin_q && SERIAL_IN_PIN)
        wue_q <= 1'b0;
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  sequence s_fall;
    wue_q && !SLEEP && pin_q && !SERIAL_IN_PIN;
  endsequence
  sequence s_div_wr;
    WR && ADDR == `URXW_ADDR_DIVL;
  endsequence
  property p_div_back;
    logic [7:0] d;
    (s_div_wr, d = WDATA) ##1 (RD && ADDR == `URXW_ADDR_DIVL) |=> RDATA == d;
  endproperty
  a_irq_follows_flag: assert property (RX_IRQ == (RECEIVE_FLAG && ie_q))
    else $error("irq does not follow flag and enable");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (RD && ADDR == 3'h7 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_div_readback: assert property (p_div_back)
    else $error("divisor low readback wrong");
  a_irq_read: assert property (RD && ADDR == `URXW_ADDR_IRQC && !SLEEP
    |=> RDATA[1:0] == {$past(RECEIVE_FLAG), $past(ie_q)})
    else $error("irq control read wrong");
  a_flag_holds: assert property (RECEIVE_FLAG && !SLEEP && !hold_rd
    |=> RECEIVE_FLAG)
    else $error("flag dropped without holding read");
  a_hold_clears: assert property (hold_rd && !SLEEP && SERIAL_IN_PIN
    && !wue_q |=> !RECEIVE_FLAG)
    else $error("holding read left flag set");
  a_flag_cause: assert property ($rose(RECEIVE_FLAG) && !SLEEP
    |-> (on_q && !sync_q) || wue_q)
    else $error("flag rose while receiver disabled");
  a_wake_fall: assert property (s_fall |-> ##[1:5] RECEIVE_FLAG)
    else $error("wake fall did not set flag");
  a_sleep_wake: assert property (wue_q && SLEEP && !SERIAL_IN_PIN
    |-> ##[0:3] RECEIVE_FLAG)
    else $error("sleep wake did not set flag");
endmodule : urxw_checker

// ---- urxw_sender.sv ----
`timescale 1ns/100ps
// remote transmitter; the line is pulled high between frames
module urxw_sender
(
  // clock
  input wire logic clk,
  // line
  output logic line
);
  int bit_cyc = 32;
  initial line = 1'b1;
  task automatic hold(input logic v, input int nbits);
    line <= v;
    repeat (nbits * bit_cyc) @(posedge clk);
  endtask : hold
  // one idle bit after the stop gives the receiver room to settle
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++)
      hold(d[i], 1);
    hold(stop, 1);
    hold(1'b1, 1);
  endtask : send
endmodule : urxw_sender

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "urxw_cfg.svh"
module tb_top;
  logic CLOCK;
  logic RST_N;
  logic SERIAL_IN_PIN;
  logic SLEEP;
  logic [2:0] ADDR;
  logic [7:0] WDATA;
  logic WR;
  logic RD;
  logic [7:0] RDATA;
  logic RECEIVE_FLAG;
  logic RX_IRQ;
  logic line;
  logic inv;
  logic rd_p;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  // all four divisor schemes: narrow fast, narrow slow, wide fast, wide with high-speed clear (also fast)
  logic [7:0] mb[4] = '{8'h00, 8'h00, 8'h08, 8'h08};
  logic [7:0] mt[4] = '{8'h04, 8'h00, 8'h04, 8'h00};
  int mc[4] = '{32, 128, 32, 32};
  logic [2:0] da[3] = '{`URXW_ADDR_RCSC, `URXW_ADDR_RCSC, `URXW_ADDR_TXSC};
  logic [7:0] dd[3] = '{8'h80, 8'h10, 8'h14};
  assign SERIAL_IN_PIN = line ^ inv;
  urxw_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .SERIAL_IN_PIN(SERIAL_IN_PIN),
    .SLEEP(SLEEP), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RECEIVE_FLAG(RECEIVE_FLAG), .RX_IRQ(RX_IRQ));
  urxw_sender u_snd (.clk(CLOCK), .line(line));
  always #5 CLOCK = ~CLOCK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task check(input logic [7:0] got, input logic [7:0] want, input string w);
    checked++;
    if (got !== want)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, w, got, want);
    end
  endtask : check
  task final_report;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  // each bus task is entered right after a rising edge
  task wr(input logic [2:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CLOCK);
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] v, input logic [7:0] m);
    ADDR <= a;
    RD <= 1'b1;
    WR <= 1'b0;
    exp_q.push_back({m, v});
    @(posedge CLOCK);
  endtask : rd
  task cyc(input int n);
    WR <= 1'b0;
    RD <= 1'b0;
    repeat (n) @(posedge CLOCK);
  endtask : cyc
  task tx(input logic [8:0] d, input int nb, input logic stop);
    cyc(1);
    u_snd.send(d, nb, stop);
  endtask : tx
  // the irq enable is held set wherever this task is called
  task flag(input logic f);
    check({7'h00, RECEIVE_FLAG}, {7'h00, f}, "receive flag");
    check({7'h00, RX_IRQ}, {7'h00, f}, "irq line");
  endtask : flag
  always @(posedge CLOCK)
    rd_p <= RD;
  always @(negedge CLOCK)
    if (rd_p)
    begin
      e = exp_q.pop_front();
      check(RDATA & e[15:8], e[7:0] & e[15:8], "read data");
    end
  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      $display("[ERR] %0t run too long", $time);
      final_report();
    end
  end
  initial
  begin
    CLOCK = 1'b0;
    RST_N = 1'b0;
    SLEEP = 1'b0;
    ADDR = 3'h0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    inv = 1'b0;
    seed = 32'd10;
    repeat (12) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    for (int a = 0; a < 8; a++)
      if (a != 1 && a != 3)
        rd(a[2:0], 8'h00, 8'hff);
    wr(`URXW_ADDR_DIVL, 8'h01);
    rd(`URXW_ADDR_DIVL, 8'h01, 8'hff);
    wr(`URXW_ADDR_IRQC, 8'h01);
    wr(`URXW_ADDR_RCSC, 8'h90);
    for (int k = 0; k < 4; k++)
    begin
      wr(`URXW_ADDR_BAUD, mb[k]);
      wr(`URXW_ADDR_TXSC, mt[k]);
      u_snd.bit_cyc = mc[k];
      seed = xs(seed);
      tx({1'b0, seed[7:0]}, 8, 1'b1);
      flag(1'b1);
      rd(`URXW_ADDR_IRQC, 8'h03, 8'h03);
      rd(`URXW_ADDR_HOLD, seed[7:0], 8'hff);
      cyc(2);
      flag(1'b0);
    end
    wr(`URXW_ADDR_RCSC, 8'hd0);
    tx(9'h1a5, 9, 1'b1);
    rd(`URXW_ADDR_RCSC, 8'hd1, 8'hff);
    rd(`URXW_ADDR_HOLD, 8'ha5, 8'hff);
    wr(`URXW_ADDR_RCSC, 8'hd8);
    tx(9'h033, 9, 1'b1);
    flag(1'b0);
    tx(9'h155, 9, 1'b1);
    rd(`URXW_ADDR_HOLD, 8'h55, 8'hff);
    wr(`URXW_ADDR_RCSC, 8'hd0);
    tx(9'h077, 9, 1'b1);
    rd(`URXW_ADDR_HOLD, 8'h77, 8'hff);
    wr(`URXW_ADDR_RCSC, 8'h98);
    tx(9'h066, 8, 1'b1);
    rd(`URXW_ADDR_HOLD, 8'h66, 8'hff);
    wr(`URXW_ADDR_RCSC, 8'h90);
    tx(9'h03c, 8, 1'b0);
    rd(`URXW_ADDR_RCSC, 8'h04, 8'h04);
    rd(`URXW_ADDR_HOLD, 8'h3c, 8'hff);
    tx(9'h011, 8, 1'b1);
    tx(9'h022, 8, 1'b1);
    rd(`URXW_ADDR_RCSC, 8'h02, 8'h06);
    wr(`URXW_ADDR_IRQC, 8'h00);
    cyc(1);
    check({7'h00, RX_IRQ}, 8'h00, "masked irq");
    wr(`URXW_ADDR_IRQC, 8'h01);
    wr(`URXW_ADDR_RCSC, 8'h80);
    // the overrun bit drops one cycle after the enable is cleared
    cyc(1);
    rd(`URXW_ADDR_RCSC, 8'h00, 8'h02);
    rd(`URXW_ADDR_HOLD, 8'h11, 8'hff);
    wr(`URXW_ADDR_RCSC, 8'h90);
    for (int k = 0; k < 3; k++)
    begin
      wr(da[k], dd[k]);
      tx(9'h0f0, 8, 1'b1);
      flag(1'b0);
      wr(`URXW_ADDR_TXSC, 8'h04);
      wr(`URXW_ADDR_RCSC, 8'h90);
    end
    cyc(1);
    SLEEP <= 1'b1;
    tx(9'h0f0, 8, 1'b1);
    flag(1'b0);
    SLEEP <= 1'b0;
    // the polarity swap costs a short false start that must be rejected
    wr(`URXW_ADDR_BAUD, 8'h28);
    inv <= 1'b1;
    cyc(40);
    tx(9'h0c3, 8, 1'b1);
    rd(`URXW_ADDR_HOLD, 8'hc3, 8'hff);
    wr(`URXW_ADDR_BAUD, 8'h08);
    inv <= 1'b0;
    cyc(40);
    wr(`URXW_ADDR_BAUD, 8'h0a);
    tx(9'h000, 8, 1'b1);
    flag(1'b1);
    rd(`URXW_ADDR_BAUD, 8'h00, 8'h02);
    rd(`URXW_ADDR_HOLD, 8'h00, 8'h00);
    wr(`URXW_ADDR_BAUD, 8'h0a);
    SLEEP <= 1'b1;
    fork
      u_snd.hold(1'b0, 12);
      begin
        cyc(5);
        flag(1'b1);
      end
    join
    SLEEP <= 1'b0;
    u_snd.hold(1'b1, 1);
    rd(`URXW_ADDR_BAUD, 8'h00, 8'h02);
    rd(`URXW_ADDR_HOLD, 8'h00, 8'h00);
    cyc(3);
    flag(1'b0);
    final_report();
  end
endmodule : tb_top
bind urxw_top urxw_checker u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .SERIAL_IN_PIN(SERIAL_IN_PIN), .SLEEP(SLEEP), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .RECEIVE_FLAG(RECEIVE_FLAG),
  .RX_IRQ(RX_IRQ));
